// ### hw/sws_pkg.sv
/*
  Shared definitions for the sleep and wake sequencer: register offsets,
  field positions, reset values, state enumeration and the register bus
  carrier struct. Assumes a 32-bit APB register bus.
*/
package sws_pkg;

  // Printed offsets are not multiples of four, so they are indices.
  localparam logic [11:0] IDX_VOLTAGE_MONITOR_CONTROL  = 12'h01e3;
  localparam logic [11:0] IDX_VOLTAGE_COMPARATOR_STATE = 12'h01e4;
  localparam logic [11:0] IDX_MONITOR_DUTY_TRIM        = 12'h01eb;
  localparam logic [11:0] IDX_SYSTEM_STATUS_CONTROL    = 12'h01f0;
  localparam logic [11:0] IDX_INT_PENDING              = 12'h01f1;
  localparam logic [11:0] IDX_INT_MASK                 = 12'h01f2;

  // Voltage monitor control fields.
  localparam int LV_TRIP_LSB   = 0;
  localparam int LEVEL_LSB     = 4;
  localparam logic [7:0] VMC_MASK  = 8'h37;
  localparam logic [7:0] VMC_RESET = 8'h00;
  // Duty trim fields.
  localparam int DUTY_LSB      = 6;
  localparam logic [7:0] DUTY_MASK  = 8'hc0;
  localparam logic [7:0] DUTY_RESET = 8'h00;
  // System status control fields.
  localparam int SSC_SLEEP     = 3;
  localparam int SSC_HALT      = 0;
  localparam logic [7:0] SSC_RESET = 8'h00;

  // Supply reset level codes.
  localparam logic [1:0] LEVEL_OFF = 2'h3;

  // Duty-cycle on-times in slow clock periods.
  localparam logic [9:0] DUTY_ON_00 = 10'h080;
  localparam logic [9:0] DUTY_ON_01 = 10'h200;
  localparam logic [9:0] DUTY_ON_10 = 10'h020;
  localparam logic [9:0] DUTY_ON_11 = 10'h008;

  // Slow oscillator periods for oscillator recovery after wake.
  localparam logic [1:0] OSC_RECOVER_PERIODS = 2'h3;

  // Wake time limits, in microseconds, and the processor clock rate.
  localparam int WAKE_MIN_US = 75;
  localparam int WAKE_MAX_US = 105;
  localparam int CLK_MHZ     = 10;
  localparam int WAKE_MAX_CYC = WAKE_MAX_US * CLK_MHZ;

  typedef enum {
    ST_AWAKE,
    ST_HALT_REQ,
    ST_WAIT_FALL,
    ST_ASLEEP,
    ST_WAKE_SYNC,
    ST_POWER_UP,
    ST_SAMPLE,
    ST_RELEASE
  } sws_state_e;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } sws_apb_req_s;

endpackage

// ### hw/sws_edge_sync.sv
/*
  Two-flop synchroniser with edge detection for a slow clock sampled by
  the processor clock. Assumes the sampled clock is far slower than clk.
*/
`timescale 1ns/1ns
module sws_edge_sync (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic async_in,
  output logic      level,
  output logic      rise,
  output logic      fall
);

  logic meta;
  logic sync;
  logic prev;

  // The first flop feeds only the second; edges come from later stages.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      meta <= 1'b0;
      sync <= 1'b0;
      prev <= 1'b0;
    end else begin
      meta <= async_in;
      sync <= meta;
      prev <= sync;
    end
  end

  assign level = sync;
  assign rise  = sync & ~prev;
  assign fall  = ~sync & prev;

endmodule // sws_edge_sync

// ### hw/sws_top.sv
/*
  Sleep entry and wake sequencer with supply-monitor configuration,
  reached over APB. Assumes the processor core answers the halt request
  with an acknowledge after any number of clocks, that the slow oscillator and
  the analog comparators arrive asynchronously, and that the system clock
  clk is the processor clock.
*/
// How it works
// - Sleep bit halts execution until interrupt or reset
// - Only unmasked pending interrupts wake the device
// - Wake resumes only while halt bit clear
// - Sleep forces internal oscillator; three-period recovery (here held until the first APB write after wake)
// - Internal fast oscillator restarts immediately on wake
// - Post-sleep instruction runs before interrupt service
// - Sleep bit immediately raises halt request
// - After acknowledge, falling edge asserts power-down
// - Power-down turns off flash, oscillator, filter, bandgap
// - Wake interrupt synchronised on slow falling edge
// - Next slow rising edge negates power-down
// - Following slow rising edge samples monitor outputs
// - Next slow falling edge drops halt request
// - Wake takes between 75 and 105 microseconds
// - Slow oscillator runs in sleep, optional low-power
// - Sleep duty-cycles the low-voltage detector
// - Duty field selects 128, 512, 32, 8 periods
// - Comparator register shows detector and reset outputs
// - Sleep timer interrupt wakes and ticks awake
`timescale 1ns/1ns
module sws_top #(
  parameter int NUM_IRQ = 8
) (
  input  wire logic               clk,
  input  wire logic               resetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [31:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic               slow_clk,
  input  wire logic [NUM_IRQ-1:0] irq_in,
  input  wire logic               halt_acknowledge,
  input  wire logic               lvd_comp,
  input  wire logic               supply_reset_comp,
  output logic                    halt_request,
  output logic                    power_down_line,
  output logic                    force_internal_osc,
  output logic                    osc_restart,
  output logic                    slow_osc_low_power,
  output logic                    monitor_enable,
  output logic      [2:0]         lv_trip_select,
  output logic      [1:0]         supply_reset_level,
  output logic                    supply_reset_enable,
  output logic                    cpu_ready
);

  // The read mux and the mask write carry at most one 32-bit word of sources.
  if (NUM_IRQ < 1 || NUM_IRQ > 32) begin : g_irq_range
    $error("NUM_IRQ must lie between 1 and 32");
  end

  sws_pkg::sws_state_e state;
  sws_pkg::sws_state_e next_state;
  sws_pkg::sws_apb_req_s req;

  logic [7:0]         voltage_monitor_control;
  logic [7:0]         monitor_duty_trim;
  logic [7:0]         system_status_control;
  logic [NUM_IRQ-1:0] int_mask;
  logic [NUM_IRQ-1:0] int_pending;
  logic               slow_low_power_cfg;
  logic [1:0]         lvd_meta;
  logic [1:0]         lvd_sync;
  logic [1:0]         cmp_sample;
  logic [NUM_IRQ-1:0] irq_meta;
  logic [NUM_IRQ-1:0] irq_sync;
  logic [9:0]         duty_cnt;
  logic [1:0]         recover_cnt;
  logic               slow_level;
  logic               slow_rise;
  logic               slow_fall;
  logic               clk_fall_seen;

  assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};

  // Slow clock edges seen in the processor clock domain.
  sws_edge_sync u_slow_sync (
    .clk      (clk),
    .resetn   (resetn),
    .async_in (slow_clk),
    .level    (slow_level),
    .rise     (slow_rise),
    .fall     (slow_fall)
  );

  // Asynchronous comparator and interrupt inputs pass two flops.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      lvd_meta <= 2'h0;
      lvd_sync <= 2'h0;
      irq_meta <= '0;
      irq_sync <= '0;
    end else begin
      lvd_meta <= {lvd_comp, supply_reset_comp};
      lvd_sync <= lvd_meta;
      irq_meta <= irq_in;
      irq_sync <= irq_meta;
    end
  end

  // Bus decode: index times four gives the byte address.
  wire        wr_en   = req.psel & req.penable & req.pwrite & (req.paddr[31:14] == 18'h0_0000);
  wire [11:0] idx     = req.paddr[13:2];
  wire        hit_vmc = (idx == sws_pkg::IDX_VOLTAGE_MONITOR_CONTROL);
  wire        hit_vcs = (idx == sws_pkg::IDX_VOLTAGE_COMPARATOR_STATE);
  wire        hit_dty = (idx == sws_pkg::IDX_MONITOR_DUTY_TRIM);
  wire        hit_ssc = (idx == sws_pkg::IDX_SYSTEM_STATUS_CONTROL);
  wire        hit_pnd = (idx == sws_pkg::IDX_INT_PENDING);
  wire        hit_msk = (idx == sws_pkg::IDX_INT_MASK);
  wire        mapped  = (req.paddr[31:14] == 18'h0_0000) &
                        (hit_vmc | hit_vcs | hit_dty | hit_ssc | hit_pnd | hit_msk);

  // Wake qualification ignores any global enable; only the mask counts.
  wire [NUM_IRQ-1:0] wake_vec   = int_pending & int_mask;
  wire               wake_req   = |wake_vec;
  wire               halt_bit   = system_status_control[sws_pkg::SSC_HALT];
  wire               sleep_bit  = system_status_control[sws_pkg::SSC_SLEEP];
  wire               sleep_wr   = wr_en & hit_ssc & req.pwdata[sws_pkg::SSC_SLEEP];
  wire [1:0]         duty_code  = monitor_duty_trim[sws_pkg::DUTY_LSB +: 2];
  wire [1:0]         level_code = voltage_monitor_control[sws_pkg::LEVEL_LSB +: 2];

  // On-time of the monitors per duty code, in slow periods.
  wire [9:0] duty_on = (duty_code == 2'h0) ? sws_pkg::DUTY_ON_00 :
                       (duty_code == 2'h1) ? sws_pkg::DUTY_ON_01 :
                       (duty_code == 2'h2) ? sws_pkg::DUTY_ON_10 :
                                             sws_pkg::DUTY_ON_11;

  // Read data; reserved bits come back as zero.
  wire [7:0] cmp_read = {6'h00, lvd_sync};
  wire [31:0] rd_mux =
    hit_vmc ? {24'h00_0000, voltage_monitor_control} :
    hit_vcs ? {24'h00_0000, cmp_read} :
    hit_dty ? {24'h00_0000, monitor_duty_trim} :
    hit_ssc ? {24'h00_0000, system_status_control} :
    hit_pnd ? 32'(int_pending) :
    hit_msk ? 32'(int_mask) : 32'h0000_0000;

  // Sequencer: entry on processor clock, wake paced by slow clock edges.
  always_comb begin
    next_state = state;
    case (state)
      sws_pkg::ST_AWAKE: begin
        if (sleep_wr) begin
          next_state = sws_pkg::ST_HALT_REQ;
        end
      end
      sws_pkg::ST_HALT_REQ: begin
        if (halt_acknowledge) begin
          next_state = sws_pkg::ST_WAIT_FALL;
        end
      end
      sws_pkg::ST_WAIT_FALL: begin
        next_state = sws_pkg::ST_ASLEEP;
      end
      sws_pkg::ST_ASLEEP: begin
        if (wake_req && !halt_bit && slow_fall) begin
          next_state = sws_pkg::ST_POWER_UP;
        end
      end
      sws_pkg::ST_POWER_UP: begin
        if (slow_rise) begin
          next_state = sws_pkg::ST_SAMPLE;
        end
      end
      sws_pkg::ST_SAMPLE: begin
        if (slow_rise) begin
          next_state = sws_pkg::ST_RELEASE;
        end
      end
      sws_pkg::ST_RELEASE: begin
        if (slow_fall) begin
          next_state = sws_pkg::ST_AWAKE;
        end
      end
      default: begin
        next_state = sws_pkg::ST_AWAKE;
      end
    endcase
  end

  // The falling clock edge after acknowledge is modelled as the next
  // cycle, so power-down rises half a period later than ideal.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state         <= sws_pkg::ST_AWAKE;
      clk_fall_seen <= 1'b0;
    end else begin
      state         <= next_state;
      clk_fall_seen <= (state == sws_pkg::ST_WAIT_FALL);
    end
  end

  // Software registers; the sleep bit clears itself on resume.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      voltage_monitor_control <= sws_pkg::VMC_RESET;
      monitor_duty_trim       <= sws_pkg::DUTY_RESET;
      system_status_control   <= sws_pkg::SSC_RESET;
      int_mask                <= '0;
      slow_low_power_cfg      <= 1'b0;
    end else begin
      if (wr_en && hit_vmc) begin
        voltage_monitor_control <= req.pwdata[7:0] & sws_pkg::VMC_MASK;
      end
      if (wr_en && hit_dty) begin
        monitor_duty_trim <= req.pwdata[7:0] & sws_pkg::DUTY_MASK;
      end
      if (wr_en && hit_ssc) begin
        system_status_control <= req.pwdata[7:0] & 8'h09;
        slow_low_power_cfg    <= req.pwdata[7];
      end else if (state == sws_pkg::ST_RELEASE && slow_fall) begin
        system_status_control[sws_pkg::SSC_SLEEP] <= 1'b0;
      end
      if (wr_en && hit_msk) begin
        int_mask <= req.pwdata[NUM_IRQ-1:0];
      end
    end
  end

  // Pending interrupts: a new event wins over a software clear.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      int_pending <= '0;
    end else begin
      int_pending <= (int_pending & ~((wr_en && hit_pnd) ? req.pwdata[NUM_IRQ-1:0] : '0)) | irq_sync;
    end
  end

  // Monitor duty cycling: always on when awake, on for duty_on of each
  // 2*duty_on slow periods while asleep, trading latency for power.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      duty_cnt <= 10'h000;
    end else if (state != sws_pkg::ST_ASLEEP) begin
      duty_cnt <= 10'h000;
    end else if (slow_rise) begin
      duty_cnt <= (duty_cnt >= 10'((duty_on << 1) - 10'h001)) ? 10'h000 : duty_cnt + 10'h001;
    end
  end

  // Comparator values captured at the settle edge of the wake sequence.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cmp_sample <= 2'h0;
    end else if (state == sws_pkg::ST_SAMPLE && slow_rise) begin
      cmp_sample <= lvd_sync;
    end
  end

  // Oscillator recovery counts three slow periods after power-up.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      recover_cnt <= 2'h0;
    end else if (state == sws_pkg::ST_POWER_UP && slow_rise) begin
      recover_cnt <= sws_pkg::OSC_RECOVER_PERIODS;
    end else if (recover_cnt != 2'h0 && slow_rise) begin
      recover_cnt <= recover_cnt - 2'h1;
    end
  end

  // Power stays down through the power-up state until the slow rising edge.
  wire pd_hold = (next_state == sws_pkg::ST_ASLEEP) || (next_state == sws_pkg::ST_POWER_UP);

  // Registered outputs.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      halt_request        <= 1'b0;
      power_down_line     <= 1'b0;
      force_internal_osc  <= 1'b0;
      osc_restart         <= 1'b0;
      slow_osc_low_power  <= 1'b0;
      monitor_enable      <= 1'b1;
      lv_trip_select      <= 3'h0;
      supply_reset_level  <= 2'h0;
      supply_reset_enable <= 1'b1;
      cpu_ready           <= 1'b1;
      prdata              <= 32'h0000_0000;
      pready              <= 1'b0;
      pslverr             <= 1'b0;
    end else begin
      halt_request        <= (next_state != sws_pkg::ST_AWAKE);
      power_down_line     <= pd_hold;
      force_internal_osc  <= (state != sws_pkg::ST_AWAKE) ? 1'b1 : (force_internal_osc & ~wr_en);
      osc_restart         <= (state == sws_pkg::ST_POWER_UP) && (next_state == sws_pkg::ST_SAMPLE);
      slow_osc_low_power  <= slow_low_power_cfg & (state == sws_pkg::ST_ASLEEP);
      monitor_enable      <= (state != sws_pkg::ST_ASLEEP) || (duty_cnt < duty_on);
      lv_trip_select      <= voltage_monitor_control[sws_pkg::LV_TRIP_LSB +: 3];
      supply_reset_level  <= level_code;
      supply_reset_enable <= (level_code != sws_pkg::LEVEL_OFF);
      cpu_ready           <= (next_state == sws_pkg::ST_AWAKE);
      pready              <= req.psel & ~req.penable;
      pslverr             <= req.psel & ~req.penable & ~mapped;
      prdata              <= (req.psel & ~req.penable) ? rd_mux : prdata;
    end
  end

  localparam int WAKE_LIMIT = sws_pkg::WAKE_MAX_CYC;

  // Counts processor cycles from a wake decision to resumed execution.
  int wake_cyc;
  always_ff @(posedge clk) begin
    if (!resetn || state == sws_pkg::ST_AWAKE) begin
      wake_cyc <= 0;
    end else if (state != sws_pkg::ST_ASLEEP && state != sws_pkg::ST_HALT_REQ && state != sws_pkg::ST_WAIT_FALL) begin
      wake_cyc <= wake_cyc + 1;
    end
  end

  sequence s_ack_seen;
    state == sws_pkg::ST_HALT_REQ && halt_acknowledge;
  endsequence

  a_sleep_halt_req: assert property (@(posedge clk) disable iff (!resetn)
    sleep_wr && state == sws_pkg::ST_AWAKE |=> halt_request)
    else $error("halt request not raised after sleep write");
  a_power_down_ack: assert property (@(posedge clk) disable iff (!resetn)
    s_ack_seen |=> ##1 power_down_line)
    else $error("power-down not asserted after acknowledge");
  a_wake_masked: assert property (@(posedge clk) disable iff (!resetn)
    state == sws_pkg::ST_ASLEEP && !wake_req |=> state == sws_pkg::ST_ASLEEP)
    else $error("woke without unmasked pending interrupt");
  a_wake_halt_bit: assert property (@(posedge clk) disable iff (!resetn)
    state == sws_pkg::ST_ASLEEP && halt_bit |=> state == sws_pkg::ST_ASLEEP)
    else $error("woke while halt bit set");
  a_pd_drop_rise: assert property (@(posedge clk) disable iff (!resetn)
    $fell(power_down_line) |-> $past(slow_rise) && $past(state) == sws_pkg::ST_POWER_UP)
    else $error("power-down dropped off the slow clock");
  a_halt_drop_fall: assert property (@(posedge clk) disable iff (!resetn)
    $fell(halt_request) |-> $past(slow_fall) && !power_down_line)
    else $error("halt request dropped off a slow falling edge");
  a_wake_bound: assert property (@(posedge clk) disable iff (!resetn)
    wake_cyc <= WAKE_LIMIT)
    else $error("wake took longer than the limit");
  a_duty_select: assert property (@(posedge clk) disable iff (!resetn)
    duty_code == 2'h3 |-> duty_on == 10'h008)
    else $error("duty code 11 does not give eight periods");
  a_reserved_zero: assert property (@(posedge clk) disable iff (!resetn)
    (voltage_monitor_control & ~sws_pkg::VMC_MASK) == 8'h00 && (monitor_duty_trim & ~sws_pkg::DUTY_MASK) == 8'h00)
    else $error("reserved bits hold a value");
  a_level_off: assert property (@(posedge clk) disable iff (!resetn)
    level_code == sws_pkg::LEVEL_OFF |=> !supply_reset_enable)
    else $error("supply reset enabled at code 11");
endmodule // sws_top

// ### bench/sws_cpu_model.sv
/*
  Behavioural processor core for the halt handshake of the sleep
  sequencer. Assumes it shares clk and resetn with the sequencer.
*/
`timescale 1ns/1ns
module sws_cpu_model (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic halt_request,
  input  wire logic slow,
  output logic      halt_acknowledge
);
  logic [1:0] wait_cnt;

  // Slow mode holds the acknowledge back three more edges, so the sequencer cannot count on a fixed delay.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      halt_acknowledge <= 1'b0;
      wait_cnt         <= 2'h0;
    end else if (halt_request && !halt_acknowledge) begin
      if (wait_cnt == (slow ? 2'h3 : 2'h0)) begin
        halt_acknowledge <= 1'b1;
      end else begin
        wait_cnt <= wait_cnt + 2'h1;
      end
    end else if (!halt_request) begin
      halt_acknowledge <= 1'b0;
      wait_cnt         <= 2'h0;
    end
  end
endmodule // sws_cpu_model

// ### bench/sws_top_test.sv
/*
  Self-checking bench for the sleep and wake sequencer: APB master tasks,
  a free-running slow oscillator and the processor model. Assumes the
  hand-over timing of one wait-free APB access.
*/
`timescale 1ns/1ns
module sws_top_test;
  localparam int SLOW_HALF = 15259;
  localparam int PER       = 305;
  logic        clk, resetn, psel, penable, pwrite, slow_clk, halt_acknowledge, lvd_comp, supply_reset_comp, slow;
  logic [31:0] paddr, pwdata, prdata;
  logic [7:0]  irq_in;
  logic        pready, pslverr, halt_request, power_down_line, force_internal_osc, osc_restart, cpu_ready;
  logic        slow_osc_low_power, monitor_enable, supply_reset_enable;
  logic [2:0]  lv_trip_select;
  logic [1:0]  supply_reset_level;
  int          n_errors = 0;
  int          checks_done = 0;
  int          n_restart = 0;

  sws_top #(.NUM_IRQ(8)) dut (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .slow_clk(slow_clk),
    .irq_in(irq_in), .halt_acknowledge(halt_acknowledge), .lvd_comp(lvd_comp),
    .supply_reset_comp(supply_reset_comp), .halt_request(halt_request), .power_down_line(power_down_line),
    .force_internal_osc(force_internal_osc), .osc_restart(osc_restart), .slow_osc_low_power(slow_osc_low_power),
    .monitor_enable(monitor_enable), .lv_trip_select(lv_trip_select), .supply_reset_level(supply_reset_level),
    .supply_reset_enable(supply_reset_enable), .cpu_ready(cpu_ready));
  sws_cpu_model cpu (.clk(clk), .resetn(resetn), .halt_request(halt_request), .slow(slow),
    .halt_acknowledge(halt_acknowledge));

  // The two clocks have unrelated periods, so edges drift against each other.
  initial clk = 1'b0;
  always #50 clk = ~clk;
  initial slow_clk = 1'b0;
  always #SLOW_HALF slow_clk = ~slow_clk;
  // Counting high cycles of the restart strobe also catches a pulse that is too long.
  always @(posedge clk) if (osc_restart === 1'b1) n_restart++;

  task automatic end_of_test();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  task automatic check_range(input string name, input int lo, input int hi, input int got);
    checks_done++;
    if (got < lo || got > hi) begin
      n_errors++;
      $display("mismatch %s expected %0d to %0d seen %0d", name, lo, hi, got);
    end
  endtask

  // Request is held until pready is sampled high; a silent slave ends in a mismatch.
  task automatic apb(input logic w, input logic [11:0] idx, input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    int n;
    n = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {18'h0_0000, idx, 2'b00};
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    check("pready", 1'b1, pready);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] idx, input logic [31:0] wd);
    logic [31:0] d;
    logic        e;
    apb(1'b1, idx, wd, d, e);
  endtask

  task automatic rd_check(input logic [11:0] idx, input logic [31:0] exp);
    logic [31:0] d;
    logic        e;
    apb(1'b0, idx, 32'h0000_0000, d, e);
    check($sformatf("reg %0h", idx), exp, d);
    check("pslverr", 1'b0, e);
  endtask

  function automatic logic pick(input int sel);
    case (sel)
      0: return halt_request;
      1: return power_down_line;
      2: return cpu_ready;
      3: return monitor_enable;
      default: return halt_acknowledge;
    endcase
  endfunction

  task automatic wait_until(input int sel, input logic val, input int maxc, output int n);
    n = 0;
    while (pick(sel) !== val && n < maxc) begin
      @(posedge clk);
      #1;
      n++;
    end
    check($sformatf("signal %0d", sel), val, pick(sel));
  endtask

  task automatic enter_sleep(input logic [31:0] ctrl);
    int a;
    wr(sws_pkg::IDX_SYSTEM_STATUS_CONTROL, ctrl);
    wait_until(0, 1'b1, 2, a);
    wait_until(4, 1'b1, 6, a);
    wait_until(1, 1'b1, 3, a);
    check_range("pd delay", 1, 2, a);
    check("cpu ready", 1'b0, cpu_ready);
    check("forced osc", 1'b1, force_internal_osc);
  endtask

  task automatic clear_irq();
    @(posedge clk);
    irq_in <= 8'h00;
    repeat (4) @(posedge clk);
    wr(sws_pkg::IDX_INT_PENDING, 32'h0000_00ff);
  endtask

  task automatic do_wake();
    int a;
    @(posedge clk);
    irq_in <= 8'h01;
    wait_until(2, 1'b1, 2 * sws_pkg::WAKE_MAX_CYC, a);
    clear_irq();
  endtask

  task automatic t_reset();
    rd_check(sws_pkg::IDX_VOLTAGE_MONITOR_CONTROL, 32'(sws_pkg::VMC_RESET));
    rd_check(sws_pkg::IDX_VOLTAGE_COMPARATOR_STATE, 32'h0000_0000);
    rd_check(sws_pkg::IDX_MONITOR_DUTY_TRIM, 32'(sws_pkg::DUTY_RESET));
    rd_check(sws_pkg::IDX_SYSTEM_STATUS_CONTROL, 32'(sws_pkg::SSC_RESET));
    check("awake", 4'b0011, {halt_request, power_down_line, cpu_ready, monitor_enable});
  endtask

  task automatic t_config();
    logic [31:0] d;
    logic        e;
    wr(sws_pkg::IDX_VOLTAGE_MONITOR_CONTROL, 32'h0000_00ff);
    rd_check(sws_pkg::IDX_VOLTAGE_MONITOR_CONTROL, 32'h0000_0037);
    wr(sws_pkg::IDX_MONITOR_DUTY_TRIM, 32'h0000_00ff);
    rd_check(sws_pkg::IDX_MONITOR_DUTY_TRIM, 32'h0000_00c0);
    apb(1'b1, 12'h100, 32'h0000_00ff, d, e);
    check("unmapped", 1'b1, e);
    for (int i = 0; i < 8; i++) begin
      wr(sws_pkg::IDX_VOLTAGE_MONITOR_CONTROL, 32'(i[1:0]) << 4 | 32'(i[2:0]));
      @(posedge clk);
      #1;
      check("trip", i[2:0], lv_trip_select);
      check("level", i[1:0], supply_reset_level);
      check("level on", i[1:0] != sws_pkg::LEVEL_OFF, supply_reset_enable);
    end
  endtask

  task automatic t_compare();
    @(posedge clk);
    lvd_comp <= 1'b1;
    wr(sws_pkg::IDX_VOLTAGE_COMPARATOR_STATE, 32'h0000_00ff);
    rd_check(sws_pkg::IDX_VOLTAGE_COMPARATOR_STATE, 32'h0000_0002);
    lvd_comp          <= 1'b0;
    supply_reset_comp <= 1'b1;
    repeat (4) @(posedge clk);
    rd_check(sws_pkg::IDX_VOLTAGE_COMPARATOR_STATE, 32'h0000_0001);
  endtask

  // Interrupt raised ten cycles after a slow falling edge so the sync edge is a full period away.
  task automatic t_sleep_wake();
    int a, b, c, r0;
    wr(sws_pkg::IDX_INT_MASK, 32'h0000_0001);
    enter_sleep(32'h0000_0088);
    @(posedge clk);
    #1;
    check("osc low power", 1'b1, slow_osc_low_power);
    @(posedge clk);
    irq_in <= 8'h02;
    repeat (3 * PER) @(posedge clk);
    #1;
    check("masked wake", 1'b1, power_down_line);
    @(negedge slow_clk);
    repeat (10) @(posedge clk);
    irq_in <= 8'h03;
    r0 = n_restart;
    wait_until(1, 1'b0, 1200, a);
    wait_until(0, 1'b0, 600, b);
    check_range("release gap", 450, 466, b);
    wait_until(2, 1'b1, 50, c);
    check_range("wake time", sws_pkg::WAKE_MIN_US * sws_pkg::CLK_MHZ, sws_pkg::WAKE_MAX_CYC, a + b + c);
    check("restart", r0 + 1, n_restart);
    check("osc kept", 1'b1, force_internal_osc);
    clear_irq();
    rd_check(sws_pkg::IDX_SYSTEM_STATUS_CONTROL, 32'h0000_0000);
    #1;
    check("osc freed", 1'b0, force_internal_osc);
  endtask

  task automatic t_halt_block();
    @(posedge clk);
    slow <= 1'b1;
    enter_sleep(32'h0000_0009);
    @(posedge clk);
    irq_in <= 8'h01;
    repeat (3 * PER) @(posedge clk);
    #1;
    check("halted", 1'b1, power_down_line);
    wr(sws_pkg::IDX_SYSTEM_STATUS_CONTROL, 32'h0000_0008);
    do_wake();
    slow <= 1'b0;
  endtask

  task automatic t_duty(input logic [1:0] code, input int on);
    int a, exp;
    exp = on * 2 * SLOW_HALF / 100;
    wr(sws_pkg::IDX_MONITOR_DUTY_TRIM, 32'(code) << 6);
    enter_sleep(32'h0000_0008);
    wait_until(3, 1'b0, 3 * on * PER, a);
    wait_until(3, 1'b1, 2 * on * PER, a);
    wait_until(3, 1'b0, 2 * on * PER, a);
    check_range("on time", exp - 12, exp + 12, a);
    do_wake();
  endtask

  // Main sequence; inputs change only on rising edges.
  initial begin
    {resetn, psel, penable, pwrite, lvd_comp, supply_reset_comp, slow} = '0;
    paddr  = 32'h0000_0000;
    pwdata = 32'h0000_0000;
    irq_in = 8'h00;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    t_reset();
    t_config();
    t_compare();
    t_sleep_wake();
    t_halt_block();
    t_duty(2'h3, 8);
    t_duty(2'h2, 32);
    end_of_test();
  end

  // Watchdog sized for the two duty scenarios, which dominate the run.
  initial begin
    #9_500_000;
    n_errors++;
    $display("mismatch watchdog expected finish seen hang");
    end_of_test();
  end
endmodule // sws_top_test
